// [rtl/omw_map.vh]
// constants for the operating mode and wake-up controller
//
// How it works
// R1 - with fast select low, clock is fast clock divided 2..64 or the sub-clock
// R2 - running from the sub-clock stops the fast oscillator and its dividers
// R3 - fast select low with divider select 000 or 001 enters SLOW mode
// R4 - SLOW switch completes only once the slow oscillator reports ready
// R5 - fast select high, or divider select 010..111, returns to NORMAL
// R6 - fast oscillator gets 15..16 cycles before its ready bit is set
// R7 - halt with idle enable 0 enters SLEEP: system and sub-clock stop
// R8 - SLEEP clears the watchdog and holds it stopped throughout
// R9 - halt, idle enable 1, keep-on 0: clock-off idle, sub-clock runs
// R10 - halt, idle enable 1, keep-on 1: clock-on idle, both clocks run
// R11 - power-down keeps state, sets power-down flag, clears time-out flag
// R12 - wake on enabled port A falling edge, interrupt, or watchdog overflow
// R13 - watchdog wake sets time-out flag, resets only counter and stack
// R14 - power-down flag cleared by reset or watchdog clear, set by halt
// R15 - per-pin wake enable; port wake resumes after the halt
// R16 - disabled interrupt or full stack: resume after halt, request stays
// R17 - enabled interrupt with stack room: normal interrupt response
// R18 - a request already pending at entry cannot wake the device
// R19 - both oscillators share one start-up counter; sleep wake restarts fast one unless the sub-clock is selected
// R20 - after sleep wake no instruction runs until the oscillator of the selected clock is ready
// R21 - watchdog time-out while running resets device and sets time-out flag
// R22 - core gives one-cycle halt and watchdog clear strobes, stalls when gated
`ifndef OMW_MAP_VH
`define OMW_MAP_VH

// register offsets
`define OMW_MODE_OFS 2'h0
`define OMW_CTRL_OFS 2'h1
`define OMW_STAT_OFS 2'h2
`define OMW_WAKE_OFS 2'h3

// mode register fields
`define OMW_FASTSEL_BIT 0
`define OMW_IDLE_EN_BIT 1
`define OMW_LRDY_BIT 2
`define OMW_HRDY_BIT 3
`define OMW_DIV_LSB 5
`define OMW_DIV_MSB 7
// control register field
`define OMW_KEEP_BIT 7
// status register fields
`define OMW_PDOWN_BIT 0
`define OMW_TMO_BIT 1
`define OMW_ST_LSB 4
`define OMW_ST_MSB 6

// reset values
`define OMW_FASTSEL_RST 1'h1
`define OMW_DIV_RST 3'h0
`define OMW_IDLE_EN_RST 1'h0
`define OMW_KEEP_RST 1'h0
`define OMW_WAKE_RST 8'h00

// clock select codes: n means fast clock / 2^n, sub means sub-clock
`define OMW_SEL_FAST 3'h0
`define OMW_SEL_SUB 3'h7
`define OMW_DIV_BASE 4'h8

// oscillator start-up counts in oscillator ticks
`define OMW_HOSC_START 11'h010
`define OMW_LOSC_START 11'h002

`endif

// [rtl/omw_ctrl.v]
// operating mode, clock gating and wake-up controller
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "omw_map.vh"

module omw_ctrl (
  // clock and reset
  input wire clk,
  input wire nrst,
  // register port
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // cpu core strobes
  input wire halt_strobe,
  input wire watchdog_clear_instruction,
  // wake sources
  input wire [7:0] porta_in,
  input wire [7:0] irq_request,
  input wire [7:0] irq_enable,
  input wire stack_full,
  input wire wdt_overflow,
  // oscillator ticks, one-cycle pulses
  input wire hosc_tick,
  input wire losc_tick,
  // clock control
  output reg [2:0] sys_clk_sel,
  output wire sys_clk_en,
  output wire sub_clk_en,
  output reg hosc_en,
  output wire cpu_stall,
  // watchdog control
  output reg wdt_clear,
  output wire wdt_hold,
  // wake and reset results
  output reg wake_resume,
  output reg wake_irq_service,
  output reg wake_pc_sp_reset,
  output reg chip_reset_req,
  output reg [7:0] irq_wake_mask
);

  // ==========================================================
  // states
  // ==========================================================
  localparam [2:0] ST_NORMAL = 3'h0;
  localparam [2:0] ST_SLOW = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_IDLE_OFF = 3'h3;
  localparam [2:0] ST_IDLE_ON = 3'h4;
  localparam [2:0] ST_WAKE = 3'h5;

  localparam [1:0] WK_PORT = 2'h0;
  localparam [1:0] WK_IRQ = 2'h1;
  localparam [1:0] WK_IRQ_SVC = 2'h2;
  localparam [1:0] WK_WDT = 2'h3;

  // ==========================================================
  // storage
  // ==========================================================
  reg high_low_clock_select;
  reg [2:0] clock_divider_select;
  reg idle_enable;
  reg idle_sysclk_keep_on;
  reg [7:0] porta_wake_enable;
  reg power_down_flag;
  reg watchdog_timeout_flag;
  reg high_osc_ready;
  reg low_osc_ready;
  reg [2:0] state;
  reg [10:0] osc_startup_counter;
  reg cnt_busy;
  reg cnt_low;
  reg [7:0] porta_q;
  reg [1:0] wake_kind;
  reg from_sleep;
  reg sub_on;

  // ==========================================================
  // decoded requests
  // ==========================================================
  wire running;
  wire want_sub;
  wire [2:0] want_code;
  wire port_wake;
  wire [7:0] irq_new;
  wire irq_wake;
  wire irq_svc;
  wire any_wake;
  wire cnt_tick;
  wire cnt_done;
  wire wake_ready;
  wire start_hi;
  wire start_lo;
  wire [3:0] div_diff;

  // running modes and the clock that the mode bits ask for
  assign running = (state == ST_NORMAL) || (state == ST_SLOW);
  assign want_sub = ~high_low_clock_select &
                    (clock_divider_select[2:1] == 2'h0); // R3
  assign div_diff = `OMW_DIV_BASE - {1'b0, clock_divider_select};
  assign want_code = high_low_clock_select ? `OMW_SEL_FAST :
                     (want_sub ? `OMW_SEL_SUB : div_diff[2:0]); // R1 R5

  // wake sources, a pending request at entry is masked off
  assign port_wake = |(porta_q & ~porta_in & porta_wake_enable); // R15
  assign irq_new = irq_request & irq_wake_mask; // R18
  assign irq_wake = |irq_new;
  assign irq_svc = (|(irq_new & irq_enable)) & ~stack_full; // R16 R17
  assign any_wake = port_wake | irq_wake | wdt_overflow; // R12

  // shared start-up counter ticks on whichever oscillator starts
  assign cnt_tick = cnt_low ? losc_tick : hosc_tick; // R19
  assign cnt_done = cnt_busy & cnt_tick &
                    (osc_startup_counter + 11'h001 ==
                     (cnt_low ? `OMW_LOSC_START : `OMW_HOSC_START)); // R6

  // counter starts, fast one first since it gates execution
  assign start_hi = hosc_en & ~high_osc_ready & ~cnt_busy; // R19
  assign start_lo = sub_on & ~low_osc_ready & ~cnt_busy & ~start_hi;

  // wake is complete once the oscillator behind the clock is ready
  assign wake_ready = (sys_clk_sel == `OMW_SEL_SUB) ? low_osc_ready :
                      high_osc_ready; // R20

  // gated clocks and the core stall
  assign sys_clk_en = running || (state == ST_IDLE_ON); // R7 R9 R10
  assign sub_clk_en = sub_on;
  assign cpu_stall = ~running ||
                     ((sys_clk_sel != `OMW_SEL_SUB) & ~high_osc_ready); // R20 R22
  assign wdt_hold = (state == ST_SLEEP); // R8

  // ==========================================================
  // register writes
  // ==========================================================
  // software-written control bits
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_low_clock_select <= `OMW_FASTSEL_RST;
      clock_divider_select <= `OMW_DIV_RST;
      idle_enable <= `OMW_IDLE_EN_RST;
      idle_sysclk_keep_on <= `OMW_KEEP_RST;
      porta_wake_enable <= `OMW_WAKE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `OMW_MODE_OFS: begin
          high_low_clock_select <= reg_wdata[`OMW_FASTSEL_BIT];
          idle_enable <= reg_wdata[`OMW_IDLE_EN_BIT];
          clock_divider_select <= reg_wdata[`OMW_DIV_MSB:`OMW_DIV_LSB];
        end
        `OMW_CTRL_OFS: begin
          idle_sysclk_keep_on <= reg_wdata[`OMW_KEEP_BIT];
        end
        `OMW_WAKE_OFS: begin
          porta_wake_enable <= reg_wdata;
        end
        default: begin
          porta_wake_enable <= porta_wake_enable;
        end
      endcase
    end
  end

  // ==========================================================
  // register reads
  // ==========================================================
  // read data stands only in the cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OMW_MODE_OFS: begin
          reg_rdata <= {clock_divider_select, 1'b0, high_osc_ready,
                        low_osc_ready, idle_enable, high_low_clock_select};
        end
        `OMW_CTRL_OFS: begin
          reg_rdata <= {idle_sysclk_keep_on, 7'h00};
        end
        `OMW_STAT_OFS: begin
          reg_rdata <= {1'b0, state, 2'h0, watchdog_timeout_flag,
                        power_down_flag};
        end
        `OMW_WAKE_OFS: begin
          reg_rdata <= porta_wake_enable;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // status flags
  // ==========================================================
  // power-down flag: halt sets, watchdog clear clears, set wins
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_down_flag <= 1'b0; // R14
    end else if (halt_strobe && running && !wdt_overflow) begin
      power_down_flag <= 1'b1; // R11 R14
    end else if (watchdog_clear_instruction) begin
      power_down_flag <= 1'b0; // R14
    end
  end

  // time-out flag: overflow sets, halt clears, set wins
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (wdt_overflow) begin
      watchdog_timeout_flag <= 1'b1; // R13 R21
    end else if (halt_strobe && running) begin
      watchdog_timeout_flag <= 1'b0; // R11
    end
  end

  // ==========================================================
  // oscillator start-up
  // ==========================================================
  // one counter serves both oscillators
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_startup_counter <= 11'h000;
      cnt_busy <= 1'b0;
      cnt_low <= 1'b0;
      high_osc_ready <= 1'b0;
      low_osc_ready <= 1'b0;
    end else begin
      if (!hosc_en) begin
        high_osc_ready <= 1'b0;
      end else if (cnt_done && !cnt_low) begin
        high_osc_ready <= 1'b1; // R6
      end
      if (!sub_on) begin
        low_osc_ready <= 1'b0;
      end else if (cnt_done && cnt_low) begin
        low_osc_ready <= 1'b1; // R4
      end
      if (start_hi || start_lo) begin
        cnt_busy <= 1'b1; // R19
        cnt_low <= start_lo;
        osc_startup_counter <= 11'h000;
      end else if (cnt_busy && ((cnt_low && !sub_on) || (!cnt_low && !hosc_en))) begin
        cnt_busy <= 1'b0; // abandoned when its oscillator stops
      end else if (cnt_done) begin
        cnt_busy <= 1'b0;
      end else if (cnt_busy && cnt_tick) begin
        osc_startup_counter <= osc_startup_counter + 11'h001;
      end
    end
  end

  // port A history for falling-edge detection
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      porta_q <= 8'hFF;
    end else begin
      porta_q <= porta_in;
    end
  end

  // ==========================================================
  // mode state machine
  // ==========================================================
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_NORMAL;
      sys_clk_sel <= `OMW_SEL_FAST;
      hosc_en <= 1'b1;
      sub_on <= 1'b1;
      irq_wake_mask <= 8'h00;
      wake_kind <= WK_PORT;
      from_sleep <= 1'b0;
      wdt_clear <= 1'b0;
      wake_resume <= 1'b0;
      wake_irq_service <= 1'b0;
      wake_pc_sp_reset <= 1'b0;
      chip_reset_req <= 1'b0;
    end else begin
      wdt_clear <= 1'b0;
      wake_resume <= 1'b0;
      wake_irq_service <= 1'b0;
      wake_pc_sp_reset <= 1'b0;
      chip_reset_req <= 1'b0;
      case (state)
        ST_NORMAL, ST_SLOW: begin
          if (wdt_overflow) begin
            chip_reset_req <= 1'b1; // R21
          end else if (halt_strobe) begin
            wdt_clear <= 1'b1; // R8 R9 R10
            irq_wake_mask <= ~irq_request; // R18
            if (!idle_enable) begin
              state <= ST_SLEEP; // R7
              hosc_en <= 1'b0;
              sub_on <= 1'b0;
            end else if (!idle_sysclk_keep_on) begin
              state <= ST_IDLE_OFF; // R9
              hosc_en <= 1'b0;
            end else begin
              state <= ST_IDLE_ON; // R10
            end
          end else begin
            if (watchdog_clear_instruction) begin
              wdt_clear <= 1'b1;
            end
            if (want_sub && sys_clk_sel != `OMW_SEL_SUB) begin
              sub_on <= 1'b1;
              if (low_osc_ready) begin
                sys_clk_sel <= `OMW_SEL_SUB; // R4
                state <= ST_SLOW; // R3
                hosc_en <= 1'b0; // R2
              end
            end else if (!want_sub && sys_clk_sel == `OMW_SEL_SUB) begin
              hosc_en <= 1'b1; // R5
              if (high_osc_ready) begin
                sys_clk_sel <= want_code; // R6
                state <= ST_NORMAL; // R5
              end
            end else begin
              sys_clk_sel <= want_code; // R1
            end
          end
        end
        ST_SLEEP, ST_IDLE_OFF, ST_IDLE_ON: begin
          if (any_wake) begin
            from_sleep <= (state == ST_SLEEP);
            sub_on <= 1'b1;
            if (sys_clk_sel != `OMW_SEL_SUB) begin
              hosc_en <= 1'b1; // R19
            end
            if (wdt_overflow) begin
              wake_kind <= WK_WDT; // R13
            end else if (irq_wake) begin
              wake_kind <= irq_svc ? WK_IRQ_SVC : WK_IRQ; // R16 R17
            end else begin
              wake_kind <= WK_PORT; // R15
            end
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_ready) begin
            state <= (sys_clk_sel == `OMW_SEL_SUB) ? ST_SLOW : ST_NORMAL;
            irq_wake_mask <= 8'h00;
            if (from_sleep) begin
              wdt_clear <= 1'b1;
            end
            case (wake_kind)
              WK_WDT: begin
                wake_pc_sp_reset <= 1'b1; // R13
              end
              WK_IRQ_SVC: begin
                wake_irq_service <= 1'b1; // R17
              end
              default: begin
                wake_resume <= 1'b1; // R15 R16
              end
            endcase
          end
        end
        default: begin
          state <= ST_NORMAL;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [verification/omw_osc_model.sv]
// oscillator tick source standing at the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module omw_osc_model #(parameter int HDIV = 2, parameter int LDIV = 8) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fast oscillator enable from the controller
  input wire logic hosc_en,
  // sub clock enable from the controller
  input wire logic sub_en,
  // tick pulses, one cycle each
  output logic hosc_tick,
  output logic losc_tick
);
  int hcnt;
  int lcnt;
  // fast ticks only while enabled, restarting from the off state each time
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hcnt <= 0;
      lcnt <= 0;
      hosc_tick <= 1'b0;
      losc_tick <= 1'b0;
    end else begin
      hcnt <= (!hosc_en || hcnt == HDIV - 1) ? 0 : hcnt + 1;
      hosc_tick <= hosc_en && hcnt == HDIV - 1;
      lcnt <= (!sub_en || lcnt == LDIV - 1) ? 0 : lcnt + 1; // sub oscillator stops in sleep
      losc_tick <= sub_en && lcnt == LDIV - 1;
    end
  end
endmodule
`default_nettype wire

// [verification/omw_checker.sv]
// assertions on the ports of the operating mode controller
`timescale 1ns/1ps
`default_nettype none
module omw_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register read
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // core and watchdog events
  input wire logic halt_strobe,
  input wire logic wdt_overflow,
  // clock and watchdog control
  input wire logic [2:0] sys_clk_sel,
  input wire logic sys_clk_en,
  input wire logic sub_clk_en,
  input wire logic hosc_en,
  input wire logic cpu_stall,
  input wire logic wdt_clear,
  input wire logic wdt_hold,
  // results
  input wire logic wake_resume,
  input wire logic wake_irq_service,
  input wire logic wake_pc_sp_reset,
  input wire logic chip_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // read data shows only in the slot after a read
  a_read_data_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  // a taken halt clears the watchdog and stops the core
  a_halt_clears_wdt: assert property (halt_strobe && !cpu_stall && !wdt_overflow |=> wdt_clear && cpu_stall)
    else $error("halt did not clear watchdog");
  // sleep stops every clock and the watchdog
  a_sleep_all_off: assert property (wdt_hold |-> !sys_clk_en && !sub_clk_en && !hosc_en)
    else $error("clock running in sleep");
  // gated system clock always stalls the core
  a_gate_stalls_cpu: assert property (!sys_clk_en |-> cpu_stall)
    else $error("core not stalled while gated");
  // moving to the sub clock stops the fast oscillator at once
  a_sub_stops_fast: assert property ($rose(sys_clk_sel == 3'h7) |-> !hosc_en)
    else $error("fast oscillator left on");
  // leaving the sub clock needs the fast oscillator enabled 15 cycles earlier
  a_fast_settled: assert property ($past(sys_clk_sel) == 3'h7 && sys_clk_sel != 3'h7 |-> $past(hosc_en, 15))
    else $error("fast clock chosen before settling");
  // wake results are single pulses
  a_wake_single_pulse: assert property (wake_resume || wake_irq_service || wake_pc_sp_reset
    |=> !(wake_resume || wake_irq_service || wake_pc_sp_reset))
    else $error("wake pulse too long");
  // one kind of wake result at a time
  a_wake_exclusive: assert property ($onehot0({wake_resume, wake_irq_service, wake_pc_sp_reset}))
    else $error("two wake results at once");
  // overflow while running asks for a full reset
  a_run_wdt_reset: assert property (wdt_overflow && !cpu_stall |=> chip_reset_req)
    else $error("no reset on running overflow");
endmodule
bind omw_ctrl omw_checker chk (.clk, .nrst, .reg_rd, .reg_rdata, .halt_strobe, .wdt_overflow, .sys_clk_sel,
  .sys_clk_en, .sub_clk_en, .hosc_en, .cpu_stall, .wdt_clear, .wdt_hold, .wake_resume, .wake_irq_service,
  .wake_pc_sp_reset, .chip_reset_req);
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the operating mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, reg_wr, reg_rd, halt_s, wclr, stack_full, wdt_ovf, htick, ltick, rd_seen;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, porta_in, irq_request, irq_enable, pend;
  logic [15:0] seed;
  wire [7:0] reg_rdata, irq_wake_mask;
  wire [2:0] sys_clk_sel;
  wire sys_clk_en, sub_clk_en, hosc_en, cpu_stall, wdt_clear, wdt_hold, w_res, w_irq, w_pcsp, chip_rst;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  int err_count, total_checks;
  logic [7:0] mode_v[4] = '{8'h01, 8'h03, 8'h03, 8'h03};
  logic [7:0] ctrl_v[4] = '{8'h00, 8'h00, 8'h80, 8'h80};
  logic [7:0] st_v[4] = '{8'h21, 8'h31, 8'h41, 8'h41};
  logic [1:0] en_v[4] = '{2'b00, 2'b10, 2'b11, 2'b11};
  omw_ctrl dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_strobe(halt_s), .watchdog_clear_instruction(wclr),
    .porta_in(porta_in), .irq_request(irq_request), .irq_enable(irq_enable), .stack_full(stack_full),
    .wdt_overflow(wdt_ovf), .hosc_tick(htick), .losc_tick(ltick), .sys_clk_sel(sys_clk_sel),
    .sys_clk_en(sys_clk_en), .sub_clk_en(sub_clk_en), .hosc_en(hosc_en), .cpu_stall(cpu_stall),
    .wdt_clear(wdt_clear), .wdt_hold(wdt_hold), .wake_resume(w_res), .wake_irq_service(w_irq),
    .wake_pc_sp_reset(w_pcsp), .chip_reset_req(chip_rst), .irq_wake_mask(irq_wake_mask));
  omw_osc_model osc (.clk(clk), .nrst(nrst), .hosc_en(hosc_en), .sub_en(sub_clk_en), .hosc_tick(htick),
    .losc_tick(ltick));
  // ==========
  // helpers
  function automatic logic [15:0] xs(input logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wake_wait;
    int n;
    n = 0;
    while (wq.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, n < 300}, 8'h01);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========
  // clock and monitors
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) rd_seen <= reg_rd;
  // read data compared in its slot, wake results when they pulse
  always @(negedge clk) begin
    if (rd_seen) chk(reg_rdata, rq.pop_front());
    if (w_res || w_irq || w_pcsp) chk({5'h00, w_irq, w_res, w_pcsp}, wq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
  // ==========
  // main sequence
  initial begin
    {nrst, reg_wr, reg_rd, halt_s, wclr, stack_full, wdt_ovf} = '0;
    {reg_addr, reg_wdata, irq_request, irq_enable} = '0;
    porta_in = 8'hFF;
    seed = 16'hEC19; // 60441
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (100) @(posedge clk);
    rd(2'h0, 8'h0D);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h00);
    $display("reset values done");
    wr(2'h0, 8'h40);
    repeat (3) @(posedge clk);
    chk({5'h00, sys_clk_sel}, 8'h06);
    wr(2'h0, 8'h20);
    repeat (4) @(posedge clk);
    chk({4'h0, hosc_en, sys_clk_sel}, 8'h07);
    rd(2'h2, 8'h10);
    wr(2'h0, 8'h01);
    repeat (60) @(posedge clk);
    chk({4'h0, hosc_en, sys_clk_sel}, 8'h08);
    rd(2'h2, 8'h00);
    $display("mode switching done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      pend = seed[7:0] & 8'hFE;
      wr(2'h0, mode_v[i]);
      wr(2'h1, ctrl_v[i]);
      wr(2'h3, 8'h01);
      irq_request <= pend;
      irq_enable <= 8'h01;
      halt_s <= 1'b1;
      @(posedge clk);
      halt_s <= 1'b0;
      @(negedge clk);
      chk({5'h00, wdt_clear, sub_clk_en, sys_clk_en}, {6'h01, en_v[i]});
      chk({6'h00, cpu_stall, wdt_hold}, {6'h00, 1'b1, i == 0});
      chk(irq_wake_mask, ~pend);
      @(posedge clk);
      rd(2'h2, st_v[i]);
      if (i == 0) begin
        wq.push_back(8'h02);
        porta_in <= 8'hFE;
      end else if (i < 3) begin
        wq.push_back((i == 1) ? 8'h04 : 8'h02);
        irq_request <= pend | 8'h01;
        stack_full <= (i == 2);
      end else begin
        wq.push_back(8'h01);
        wdt_ovf <= 1'b1;
        @(posedge clk);
        wdt_ovf <= 1'b0;
      end
      wake_wait();
      porta_in <= 8'hFF;
      irq_request <= 8'h00;
      stack_full <= 1'b0;
      repeat (2) @(posedge clk);
    end
    rd(2'h2, 8'h03);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    @(posedge clk);
    rd(2'h2, 8'h02);
    $display("power down and wake done");
    wdt_ovf <= 1'b1;
    @(posedge clk);
    wdt_ovf <= 1'b0;
    @(negedge clk);
    chk({7'h00, chip_rst}, 8'h01);
    $display("running overflow done");
    results();
  end
endmodule
`default_nettype wire
